// file: hw/pcsc_pkg.sv
// Package with register map, field positions and types for the socket status-change block.
// Function
// RQ1 - With memory mode bit clear, an access drives register-select pin from setting bit.
// RQ2 - Flag register resets on power-up and hardware standby, holds on software reset.
// RQ3 - Writing 1 to flag bit 7 interrupts only while card-detect enable is set.
// RQ4 - Flag bit 6 picks power switch: 0 parallel type, 1 serial switch.
// RQ5 - Pulse mode: bit 5 latches on chosen IREQ edge, cleared by 0, resets to 1.
// RQ6 - Level mode: bit 5 reads inverted IREQ pin; reads 0 for memory cards.
// RQ7 - I/O card: bit 4 sets on STSCHG falling, clears by 0, memory reads 0.
// RQ8 - Bit 3 sets when either card-detect input changes; clears by writing 0.
// RQ9 - Memory card: bit 2 sets on READY rising, clears by 0, I/O reads 0.
// RQ10 - Memory card: bit 1 shows battery warning on pin change; cleared by 0.
// RQ11 - Memory card: bit 0 shows battery dead on pin change; cleared by 0.
// RQ12 - Enable bits gate matching factors; enable register holds across software reset.
// RQ13 - Change-reset enable set: card change initialises general and software control.
// RQ14 - Mode 00 no IREQ interrupt, 01 low level, 10 falling edge.
// RQ15 - Mode 11 is pulse mode interrupting on IREQ rising edge.
// RQ16 - STSCHG enable bit 4 gates the STSCHG falling-edge interrupt.
// RQ17 - Card-detect enable bit 3 gates the card-detect change interrupt.
// RQ18 - Ready enable bit 2 gates the READY rising interrupt.
// RQ19 - Battery-warning enable bit 1 gates the warning interrupt.
// RQ20 - Battery pins decode 11 good, 01 warning, 10 or 00 dead.
// RQ21 - General control bit 5 selects I/O card when 1, memory card when 0.
// RQ22 - Battery-dead enable bit 0 gates the dead interrupt.
// RQ23 - One socket interrupt output is high while any flag and its enable are set.
package pcsc_pkg;

	// ****************************************************************
	// Register byte addresses on APB.
	// ****************************************************************
	localparam logic [7:0] OFS_GEN_CTRL   = 8'h00;
	localparam logic [7:0] OFS_FLAGS      = 8'h04;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h08;
	localparam logic [7:0] OFS_SW_CTRL    = 8'h0c;
	localparam logic [7:0] OFS_RESET_CTRL = 8'h10;

	// ****************************************************************
	// Field positions and reset values.
	// ****************************************************************
	localparam int BIT_SOFT_CD    = 7;
	localparam int BIT_POWER_SWITCH_SELECT    = 6;
	localparam int BIT_IRQ_FLAG   = 5;
	localparam int BIT_STSCHG     = 4;
	localparam int BIT_CD_CHANGE  = 3;
	localparam int BIT_READY_CHG  = 2;
	localparam int BIT_BATT_WARN  = 1;
	localparam int BIT_BATT_DEAD  = 0;
	localparam int BIT_CHG_RESET  = 7;
	localparam int BIT_MODE_HI    = 6;
	localparam int BIT_MODE_LO    = 5;
	localparam int BIT_CARD_TYPE  = 5;
	localparam int BIT_MEM_MODE   = 3;
	localparam int BIT_REG_SELECT = 0;
	localparam int BIT_SW_RESET   = 0;
	localparam int BIT_HW_STANDBY = 1;
	localparam logic [7:0] RST_FLAGS  = 8'h20;
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [4:0] SW_CTRL_MASK = 5'h1f;

	// Battery pin pair decode values, pair ordered {volt_two, volt_one}.
	localparam logic [1:0] BATT_WARN = 2'h1;

	typedef enum logic [1:0] {
		IRQ_MODE_OFF,
		IRQ_MODE_LEVEL,
		IRQ_MODE_FALL,
		IRQ_MODE_RISE
	} pcsc_irq_mode_e;

	// Card-side pins sampled together.
	typedef struct packed {
		logic card_ready_input;
		logic card_detect_one_input;
		logic card_detect_two_input;
		logic battery_volt_one_input;
		logic battery_volt_two_input;
	} pcsc_pins_s;

endpackage

// file: hw/pcsc_status_irq.sv
// Socket status-change flags, interrupt enables and register-select drive.
module pcsc_status_irq
	import pcsc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       psel_in,
	input  wire logic       penable_in,
	input  wire logic       pwrite_in,
	input  wire logic [7:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]     prdata_out,
	output logic            pready_out,
	output logic            pslverr_out,
	input  wire pcsc_pins_s pins_in,
	input  wire logic       card_access_in,
	output logic            card_register_select_pin_out,
	output logic            power_switch_select_out,
	output logic            socket_irq_out
);

	// ****************************************************************
	// Register state.
	// ****************************************************************
	logic [7:0]     gen_ctrl_q;
	logic [7:0]     flags_q;
	logic           soft_cd_q;
	logic           power_switch_select_q;
	logic           irq_flag_q;
	logic           stschg_flag_q;
	logic           cd_flag_q;
	logic           ready_flag_q;
	logic           batt_warn_q;
	logic           batt_dead_q;
	logic           pulse_mode;
	logic [7:0]     irq_en_q;
	logic [4:0]     sw_ctrl_q;
	logic           hw_standby_q;
	pcsc_pins_s     pins_q;
	logic           io_card;
	logic           mem_card;
	pcsc_irq_mode_e mode;
	logic           wr_acc;
	logic           rd_acc;
	logic           wr_flags;
	logic [7:0]     wd;
	logic           cd_change;
	logic           batt_change;
	logic           irq_edge;
	logic           chg_reset;
	logic           power_up;
	logic [7:0]     flags_view;
	logic           irq_pending;

	assign io_card  = gen_ctrl_q[BIT_CARD_TYPE]; // RQ21
	assign mem_card = ~io_card; // RQ21
	assign mode = pcsc_irq_mode_e'({irq_en_q[BIT_MODE_HI],
		irq_en_q[BIT_MODE_LO]});
	assign pulse_mode = (mode == IRQ_MODE_FALL) || (mode == IRQ_MODE_RISE);
	assign wd = pwdata_in[7:0];
	assign wr_acc = psel_in & penable_in & pwrite_in;
	assign rd_acc = psel_in & ~pwrite_in;
	assign wr_flags = wr_acc & (paddr_in == OFS_FLAGS);
	// Power-up reset plus hardware standby both reinitialise the flags.
	assign power_up = rst_in | hw_standby_q; // RQ2
	// Each flag bit has its own register; this is the packed view.
	assign flags_q = {soft_cd_q, power_switch_select_q, irq_flag_q, stschg_flag_q,
		cd_flag_q, ready_flag_q, batt_warn_q, batt_dead_q};

	// Pin edges are taken against the previous sampled value.
	assign cd_change = (pins_in.card_detect_one_input
		!= pins_q.card_detect_one_input)
		| (pins_in.card_detect_two_input
		!= pins_q.card_detect_two_input);
	assign batt_change = (pins_in.battery_volt_one_input
		!= pins_q.battery_volt_one_input)
		| (pins_in.battery_volt_two_input
		!= pins_q.battery_volt_two_input);
	// The ready pin carries IREQ on I/O cards.
	assign irq_edge = (mode == IRQ_MODE_FALL)
		? (pins_q.card_ready_input & ~pins_in.card_ready_input) // RQ14
		: (~pins_q.card_ready_input & pins_in.card_ready_input); // RQ15
	assign chg_reset = cd_change & irq_en_q[BIT_CHG_RESET]; // RQ13

	// ****************************************************************
	// Pin history.
	// ****************************************************************

	// Previous pin values for edge detection. The history keeps tracking
	// the pins through reset, so no false edge appears on release.
	always_ff @(posedge clk_in) begin
		pins_q <= pins_in;
	end

	// Standby control; the software reset bit is not stored and reads 0,
	// since software reset has no effect on these registers.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hw_standby_q <= 1'b0;
		end else if (wr_acc && paddr_in == OFS_RESET_CTRL) begin
			hw_standby_q <= wd[BIT_HW_STANDBY];
		end
	end

	// ****************************************************************
	// Socket control registers.
	// ****************************************************************

	// A card swap can wipe control; it beats a same-cycle write.
	always_ff @(posedge clk_in) begin
		if (rst_in || chg_reset) begin // RQ13
			gen_ctrl_q <= RST_ZERO;
			sw_ctrl_q  <= '0;
		end else if (wr_acc && paddr_in == OFS_GEN_CTRL) begin
			gen_ctrl_q <= wd;
		end else if (wr_acc && paddr_in == OFS_SW_CTRL) begin
			sw_ctrl_q <= wd[4:0] & SW_CTRL_MASK;
		end
	end

	// Enables reset only at power-up and hold otherwise.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin // RQ12
			irq_en_q <= RST_ZERO;
		end else if (wr_acc && paddr_in == OFS_IRQ_EN) begin
			irq_en_q <= wd;
		end
	end

	// ****************************************************************
	// Status-change flags; hardware set wins over software clear.
	// ****************************************************************

	// Software-owned bits 7 and 6 are plain read/write.
	always_ff @(posedge clk_in) begin
		if (power_up) begin // RQ2
			soft_cd_q <= RST_FLAGS[BIT_SOFT_CD];
			power_switch_select_q <= RST_FLAGS[BIT_POWER_SWITCH_SELECT];
		end else if (wr_flags) begin
			soft_cd_q <= wd[BIT_SOFT_CD]; // RQ3
			power_switch_select_q <= wd[BIT_POWER_SWITCH_SELECT]; // RQ4
		end
	end

	// IREQ latch is used in the edge modes only.
	always_ff @(posedge clk_in) begin
		if (power_up) begin
			irq_flag_q <= RST_FLAGS[BIT_IRQ_FLAG]; // RQ5
		end else if (io_card && pulse_mode && irq_edge) begin
			irq_flag_q <= 1'b1; // RQ5
		end else if (wr_flags && !wd[BIT_IRQ_FLAG] && pulse_mode) begin
			// Outside pulse mode the bit is a read-only pin view.
			irq_flag_q <= 1'b0; // RQ5 RQ6
		end
	end

	// STSCHG falling edge on I/O cards.
	always_ff @(posedge clk_in) begin
		if (power_up) begin
			stschg_flag_q <= RST_FLAGS[BIT_STSCHG];
		end else if (io_card && pins_q.battery_volt_one_input
			&& !pins_in.battery_volt_one_input) begin
			stschg_flag_q <= 1'b1; // RQ7
		end else if (wr_flags && !wd[BIT_STSCHG]) begin
			stschg_flag_q <= 1'b0; // RQ7
		end
	end

	// Card-detect change regardless of card type.
	always_ff @(posedge clk_in) begin
		if (power_up) begin
			cd_flag_q <= RST_FLAGS[BIT_CD_CHANGE];
		end else if (cd_change) begin
			cd_flag_q <= 1'b1; // RQ8
		end else if (wr_flags && !wd[BIT_CD_CHANGE]) begin
			cd_flag_q <= 1'b0; // RQ8
		end
	end

	// READY rising on memory cards.
	always_ff @(posedge clk_in) begin
		if (power_up) begin
			ready_flag_q <= RST_FLAGS[BIT_READY_CHG];
		end else if (mem_card && !pins_q.card_ready_input
			&& pins_in.card_ready_input) begin
			ready_flag_q <= 1'b1; // RQ9
		end else if (wr_flags && !wd[BIT_READY_CHG]) begin
			ready_flag_q <= 1'b0; // RQ9
		end
	end

	// Battery state follows the pin pair whenever it changes on a memory card.
	always_ff @(posedge clk_in) begin
		if (power_up) begin
			batt_warn_q <= RST_FLAGS[BIT_BATT_WARN];
			batt_dead_q <= RST_FLAGS[BIT_BATT_DEAD];
		end else if (mem_card && batt_change) begin
			batt_warn_q <= ({pins_in.battery_volt_two_input,
				pins_in.battery_volt_one_input} == BATT_WARN); // RQ10 RQ20
			batt_dead_q <= ~pins_in.battery_volt_one_input; // RQ11 RQ20
		end else if (wr_flags) begin
			if (!wd[BIT_BATT_WARN]) begin
				batt_warn_q <= 1'b0; // RQ10
			end
			if (!wd[BIT_BATT_DEAD]) begin
				batt_dead_q <= 1'b0; // RQ11
			end
		end
	end

	// ****************************************************************
	// Read view and interrupt.
	// ****************************************************************

	// Type-dependent bits read zero for the wrong card type.
	always_comb begin
		flags_view = flags_q;
		if (mode == IRQ_MODE_OFF || mode == IRQ_MODE_LEVEL) begin
			flags_view[BIT_IRQ_FLAG] = ~pins_in.card_ready_input; // RQ6 RQ14
		end
		if (!io_card) begin
			flags_view[BIT_IRQ_FLAG] = 1'b0; // RQ6
			flags_view[BIT_STSCHG]   = 1'b0; // RQ7
		end else begin
			flags_view[BIT_READY_CHG] = 1'b0; // RQ9
			flags_view[BIT_BATT_WARN] = 1'b0; // RQ10
			flags_view[BIT_BATT_DEAD] = 1'b0; // RQ11
		end
	end

	// Every gated factor is ORed onto the one socket line.
	always_comb begin
		irq_pending = |(flags_view[4:0] & irq_en_q[4:0]); // RQ12 RQ16 RQ17 RQ18 RQ19 RQ22
		if (flags_q[BIT_SOFT_CD] && irq_en_q[BIT_CD_CHANGE]) begin
			irq_pending = 1'b1; // RQ3
		end
		if (io_card && mode != IRQ_MODE_OFF && flags_view[BIT_IRQ_FLAG]) begin
			irq_pending = 1'b1; // RQ14 RQ15
		end
	end

	// Interrupt and pin outputs come from flip-flops.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			socket_irq_out               <= 1'b0;
			power_switch_select_out      <= 1'b0;
			card_register_select_pin_out <= 1'b0;
		end else begin
			socket_irq_out          <= irq_pending; // RQ23
			power_switch_select_out <= flags_q[BIT_POWER_SWITCH_SELECT]; // RQ4
			if (card_access_in && !gen_ctrl_q[BIT_MEM_MODE]) begin
				card_register_select_pin_out <= gen_ctrl_q[BIT_REG_SELECT]; // RQ1
			end
		end
	end

	// APB answers in the access cycle; read data is registered at setup.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prdata_out  <= '0;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out  <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in
				& (paddr_in > OFS_RESET_CTRL | paddr_in[1:0] != 2'h0);
			if (rd_acc && !penable_in) begin
				unique case (paddr_in)
					OFS_GEN_CTRL: prdata_out <= {24'h0, gen_ctrl_q};
					OFS_FLAGS:    prdata_out <= {24'h0, flags_view};
					OFS_IRQ_EN:   prdata_out <= {24'h0, irq_en_q};
					OFS_SW_CTRL:  prdata_out <= {27'h0, sw_ctrl_q};
					OFS_RESET_CTRL: prdata_out <= {30'h0, hw_standby_q, 1'b0};
					default:      prdata_out <= 32'h0;
				endcase
			end
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************

	// Pin steps that the flag checks are built from.
	sequence s_ready_rise;
		!pins_in.card_ready_input ##1 pins_in.card_ready_input;
	endsequence
	sequence s_ready_fall;
		pins_in.card_ready_input ##1 !pins_in.card_ready_input;
	endsequence
	sequence s_stschg_fall;
		pins_in.battery_volt_one_input ##1 !pins_in.battery_volt_one_input;
	endsequence

	AST_CD_SET: assert property (@(posedge clk_in) // RQ8
		disable iff (power_up) cd_change |=> flags_q[BIT_CD_CHANGE])
		else $error("card detect change not latched");
	AST_PSW: assert property (@(posedge clk_in) disable iff (rst_in) // RQ4
		##1 power_switch_select_out == $past(flags_q[BIT_POWER_SWITCH_SELECT]))
		else $error("power switch select mismatch");
	AST_IRQ_OUT: assert property (@(posedge clk_in) // RQ23
		disable iff (rst_in) irq_pending |=> socket_irq_out)
		else $error("interrupt not raised");
	AST_NO_EN: assert property (@(posedge clk_in) // RQ12
		disable iff (rst_in)
		irq_en_q == 8'h00 && !flags_q[BIT_SOFT_CD] |=> !socket_irq_out)
		else $error("interrupt with no enable");
	AST_MEM_ZERO: assert property (@(posedge clk_in) // RQ7
		disable iff (rst_in) !io_card |-> flags_view[5:4] == 2'h0)
		else $error("io bits visible on memory card");
	AST_IO_ZERO: assert property (@(posedge clk_in) // RQ9
		disable iff (rst_in) io_card |-> flags_view[2:0] == 3'h0)
		else $error("memory bits visible on io card");
	AST_CHG_RST: assert property (@(posedge clk_in) // RQ13
		disable iff (rst_in)
		chg_reset |=> gen_ctrl_q == 8'h00 && sw_ctrl_q == 5'h00)
		else $error("change reset missed");
	AST_EN_HOLD: assert property (@(posedge clk_in) // RQ12
		disable iff (rst_in)
		!(wr_acc && paddr_in == OFS_IRQ_EN) |=> $stable(irq_en_q))
		else $error("enable changed without write");
	AST_REG_PIN: assert property (@(posedge clk_in) // RQ1
		disable iff (rst_in) card_access_in && !gen_ctrl_q[BIT_MEM_MODE]
		|=> card_register_select_pin_out
		== $past(gen_ctrl_q[BIT_REG_SELECT]))
		else $error("register select pin wrong");
	AST_STSCHG_SET: assert property (@(posedge clk_in) // RQ7
		disable iff (power_up) s_stschg_fall ##0 io_card
		|=> flags_q[BIT_STSCHG])
		else $error("status change edge not latched");
	AST_READY_SET: assert property (@(posedge clk_in) // RQ9
		disable iff (power_up) s_ready_rise ##0 mem_card
		|=> flags_q[BIT_READY_CHG])
		else $error("ready rise not latched");
	AST_IRQ_RISE: assert property (@(posedge clk_in) // RQ15
		disable iff (power_up)
		s_ready_rise ##0 (io_card && mode == IRQ_MODE_RISE)
		|=> flags_q[BIT_IRQ_FLAG])
		else $error("rising request not latched");
	AST_IRQ_FALL: assert property (@(posedge clk_in) // RQ14
		disable iff (power_up)
		s_ready_fall ##0 (io_card && mode == IRQ_MODE_FALL)
		|=> flags_q[BIT_IRQ_FLAG])
		else $error("falling request not latched");
	AST_LEVEL_VIEW: assert property (@(posedge clk_in) // RQ6
		disable iff (rst_in) io_card && !pulse_mode
		|-> flags_view[BIT_IRQ_FLAG] == !pins_in.card_ready_input)
		else $error("level mode request view wrong");
	AST_SOFT_CD: assert property (@(posedge clk_in) // RQ3
		disable iff (rst_in)
		flags_q[BIT_SOFT_CD] && irq_en_q[BIT_CD_CHANGE] |=> socket_irq_out)
		else $error("software card detect interrupt missing");
	AST_STANDBY: assert property (@(posedge clk_in) // RQ2
		disable iff (rst_in) hw_standby_q |=> flags_q == RST_FLAGS)
		else $error("standby did not reinitialise flags");

endmodule

// file: tb/pcsc_card_model.sv
// Model of the card in the socket, driving its status pins with a lag.
module pcsc_card_model
	import pcsc_pkg::*;
(
	input  wire logic       clk_in,
	input  wire pcsc_pins_s want_in,
	input  wire logic [1:0] lag_in,
	output pcsc_pins_s      pins_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Pins start high: an empty socket pulls detect and status lines up.
	pcsc_pins_s pins_q = '1;
	logic [1:0] wait_q = '0;

	assign pins_out = pins_q;

	// A real card settles slowly, so a new pin state lands after a lag.
	always @(posedge clk_in) begin
		if (want_in === pins_q) begin
			wait_q <= '0;
		end else if (wait_q >= lag_in) begin
			pins_q <= want_in;
			wait_q <= '0;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end
endmodule

// file: tb/tb_pc_card_status_change_irq.sv
// Self-checking bench for the socket status-change and interrupt block.
module tb_pc_card_status_change_irq
	import pcsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        access = 1'b0;
	logic [1:0]  lag = 2'h0;
	pcsc_pins_s  want = '1;
	pcsc_pins_s  pins;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        reg_sel;
	logic        psw;
	logic        irq;
	logic        serr;
	logic [31:0] exp_q[$];
	logic [7:0]  lfsr = 8'h35;
	int          err_count = 0;
	int          checked = 0;

	always #5 clk_in = ~clk_in;

	pcsc_status_irq dut_u (.clk_in(clk_in), .rst_in(rst_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .pins_in(pins),
		.card_access_in(access), .card_register_select_pin_out(reg_sel),
		.power_switch_select_out(psw), .socket_irq_out(irq));

	pcsc_card_model card_u (.clk_in(clk_in), .want_in(want),
		.lag_in(lag), .pins_out(pins));

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high or 20 cycles pass.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_in);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 20);
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			test_done();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, a, 8'h00);
	endtask

	task automatic rf(input logic [7:0] e);
		rd(OFS_FLAGS, e);
	endtask

	// Flag then interrupt each take one registered stage to show.
	task automatic ci(input logic e);
		repeat (3) @(posedge clk_in);
		chk("socket_irq", {31'h0, e}, {31'h0, irq});
	endtask

	// New pins go out with a random card lag, then time to settle.
	task automatic settle();
		lfsr = nxt(lfsr);
		lag <= lfsr[1:0];
		repeat (8) @(posedge clk_in);
	endtask

	// Read data is judged in the cycle the slave answers.
	always @(posedge clk_in) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_q.size() > 0) begin
				chk("prdata", exp_q.pop_front(), prdata);
			end
		end
	end

	// ****************************************************************
	// Stimulus.
	// ****************************************************************
	initial begin
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(OFS_GEN_CTRL, 8'h00);
		rf(8'h00);
		rd(OFS_IRQ_EN, 8'h00);
		rd(OFS_SW_CTRL, 8'h00);
		rd(8'h14, 8'h00);
		chk("pslverr", 32'h1, {31'h0, serr});
		lfsr = nxt(lfsr);
		wr(OFS_IRQ_EN, lfsr);
		rd(OFS_IRQ_EN, lfsr);
		wr(OFS_IRQ_EN, 8'h00);
		$display("reset test done");
		wr(OFS_IRQ_EN, 8'h08);
		want.card_detect_one_input <= 1'b0;
		settle();
		rf(8'h08);
		ci(1'b1);
		wr(OFS_FLAGS, 8'h08);
		rf(8'h08);
		wr(OFS_FLAGS, 8'h00);
		rf(8'h00);
		ci(1'b0);
		wr(OFS_IRQ_EN, 8'h00);
		want.card_detect_two_input <= 1'b0;
		settle();
		rf(8'h08);
		ci(1'b0);
		wr(OFS_FLAGS, 8'h00);
		$display("card detect test done");
		want.card_ready_input <= 1'b0;
		settle();
		rf(8'h00);
		wr(OFS_IRQ_EN, 8'h04);
		want.card_ready_input <= 1'b1;
		settle();
		rf(8'h04);
		ci(1'b1);
		wr(OFS_FLAGS, 8'h00);
		wr(OFS_IRQ_EN, 8'h03);
		for (int i = 0; i < 4; i++) begin
			logic [1:0] p;
			p = 2'(8'h4b >> (2 * i));
			want.battery_volt_two_input <= p[1];
			want.battery_volt_one_input <= p[0];
			settle();
			rf({6'h0, p == BATT_WARN, !p[0]});
			ci(p != 2'h3);
		end
		wr(OFS_IRQ_EN, 8'h00);
		wr(OFS_FLAGS, 8'h00);
		$display("memory card test done");
		wr(OFS_FLAGS, 8'hc0);
		rf(8'hc0);
		chk("power_switch", 32'h1, {31'h0, psw});
		ci(1'b0);
		wr(OFS_IRQ_EN, 8'h08);
		ci(1'b1);
		wr(OFS_IRQ_EN, 8'h00);
		wr(OFS_FLAGS, 8'h00);
		// The select pin follows the flag one registered stage later.
		repeat (2) @(posedge clk_in);
		chk("power_switch", 32'h0, {31'h0, psw});
		wr(OFS_GEN_CTRL, 8'h01);
		access <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk("reg_select", 32'h1, {31'h0, reg_sel});
		access <= 1'b0;
		wr(OFS_GEN_CTRL, 8'h08);
		access <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk("reg_select", 32'h1, {31'h0, reg_sel});
		access <= 1'b0;
		wr(OFS_GEN_CTRL, 8'h00);
		access <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk("reg_select", 32'h0, {31'h0, reg_sel});
		access <= 1'b0;
		$display("select test done");
		wr(OFS_GEN_CTRL, 8'h20);
		want.card_ready_input <= 1'b0;
		settle();
		rf(8'h20);
		ci(1'b0);
		wr(OFS_IRQ_EN, 8'h20);
		ci(1'b1);
		want.card_ready_input <= 1'b1;
		settle();
		rf(8'h00);
		wr(OFS_IRQ_EN, 8'h40);
		wr(OFS_FLAGS, 8'h00);
		want.card_ready_input <= 1'b0;
		settle();
		rf(8'h20);
		ci(1'b1);
		wr(OFS_FLAGS, 8'h20);
		rf(8'h20);
		wr(OFS_FLAGS, 8'h00);
		want.card_ready_input <= 1'b1;
		settle();
		rf(8'h00);
		wr(OFS_IRQ_EN, 8'h60);
		want.card_ready_input <= 1'b0;
		settle();
		rf(8'h00);
		want.card_ready_input <= 1'b1;
		settle();
		rf(8'h20);
		ci(1'b1);
		wr(OFS_FLAGS, 8'h00);
		wr(OFS_IRQ_EN, 8'h10);
		want.battery_volt_one_input <= 1'b0;
		settle();
		rf(8'h10);
		ci(1'b1);
		wr(OFS_FLAGS, 8'h10);
		rf(8'h10);
		wr(OFS_FLAGS, 8'h00);
		rf(8'h00);
		want.battery_volt_one_input <= 1'b1;
		settle();
		$display("io card test done");
		wr(OFS_SW_CTRL, 8'h1f);
		wr(OFS_IRQ_EN, 8'h80);
		want.card_detect_one_input <= 1'b1;
		settle();
		rd(OFS_GEN_CTRL, 8'h00);
		rd(OFS_SW_CTRL, 8'h00);
		wr(OFS_GEN_CTRL, 8'h20);
		wr(OFS_IRQ_EN, 8'h0c);
		want.card_detect_one_input <= 1'b0;
		settle();
		rd(OFS_GEN_CTRL, 8'h20);
		rf(8'h08);
		wr(OFS_RESET_CTRL, 8'h02);
		wr(OFS_RESET_CTRL, 8'h00);
		rf(8'h00);
		rd(OFS_IRQ_EN, 8'h0c);
		$display("standby test done");
		test_done();
	end
endmodule
